// ### hw/rsw_reset_wdog.sv
// rsw_reset_wdog: reset sources, start-up stretch, cause flags and watchdog
// assumes synchronous inputs, a watchdog oscillator tick strobe and an APB master
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module rsw_reset_wdog #(
  parameter logic [15:0] STARTUP_CYCLES = rsw_pkg::STARTUP_DEFAULT,
  parameter logic [20:0] WDOG_BASE      = rsw_pkg::WD_BASE
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  input  wire logic                  i_clk_en,
  input  wire rsw_pkg::rsw_apb_req_s i_apb,
  output rsw_pkg::rsw_apb_rsp_s      o_apb,
  input  wire rsw_pkg::rsw_fuse_s    i_fuse,
  input  wire logic                  i_reset_pin_n,
  input  wire logic                  i_power_low,
  input  wire logic                  i_supply_below_level,
  input  wire logic                  i_wdog_osc_tick,
  input  wire logic                  i_wdog_restart,
  input  wire logic                  i_wdog_vector_ack,
  output logic                       o_core_reset,
  output logic                       o_wdog_irq,
  output logic                       o_wdog_wake,
  output logic                       o_supply_drop_detector_en,
  output rsw_pkg::rsw_level_e        o_supply_drop_level
);

  // decoded APB access and register select
  function automatic logic [1:0] reg_sel(input logic [7:0] addr);
    reg_sel = 2'h0;
    if (addr == rsw_pkg::ADDR_CAUSE) begin
      reg_sel = 2'h1;
    end else if (addr == rsw_pkg::ADDR_WDCTL) begin
      reg_sel = 2'h2;
    end
  endfunction : reg_sel

  logic                pin_low_r;
  logic [8:0]          pin_cnt_r;
  logic                drop_r;
  logic [3:0]          drop_cnt_r;
  logic                pwr_r;
  logic                wd_pulse_r;
  logic [15:0]         dly_cnt_r;
  logic                core_rst_r;
  logic                any_src;
  logic [7:0]          cause_r;
  logic                wdog_irq_flag_r;
  logic                wdog_irq_enable_r;
  logic                wde_r;
  logic [3:0]          wdp_r;
  logic                wdog_change_enable_r;
  logic [2:0]          ce_cnt_r;
  logic [20:0]         wd_cnt_r;
  logic [20:0]         wd_limit;
  logic [3:0]          wdp_use;
  logic                wde_eff;
  logic                wdog_irq_enable_eff;
  logic                wd_expire;
  logic                wd_irq_set;
  logic                wd_rst_req;
  logic                irq_r;
  logic                wake_r;
  logic                det_en_r;
  rsw_pkg::rsw_level_e level_r;
  rsw_pkg::rsw_wdmode_e wd_mode;
  rsw_pkg::rsw_apb_rsp_s apb_r;
  logic                acc;
  logic                wr_cause;
  logic                wr_ctl;
  logic [7:0]          wdat;
  logic                ce_open;

  assign wdat     = i_apb.pwdata[7:0];
  assign acc      = i_apb.psel & i_apb.penable & apb_r.pready;
  assign wr_cause = acc & i_apb.pwrite & (reg_sel(i_apb.paddr) == 2'h1);
  assign wr_ctl   = acc & i_apb.pwrite & (reg_sel(i_apb.paddr) == 2'h2);
  // opening write of a protected change
  assign ce_open  = wr_ctl & wdat[rsw_pkg::WD_CE_BIT] & wdat[rsw_pkg::WD_RE_BIT];

  // fuse decode for the supply drop detector
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      det_en_r <= 1'b0;
      level_r  <= rsw_pkg::LEVEL_NONE;
    end else if (i_clk_en) begin
      det_en_r <= 1'b1;
      case (i_fuse.drop_level)
        rsw_pkg::LVL_1V8: level_r <= rsw_pkg::LEVEL_1V8;
        rsw_pkg::LVL_2V7: level_r <= rsw_pkg::LEVEL_2V7;
        rsw_pkg::LVL_4V3: level_r <= rsw_pkg::LEVEL_4V3;
        default: begin
          level_r  <= rsw_pkg::LEVEL_NONE; // off and reserved codes
          det_en_r <= 1'b0;
        end
      endcase
    end
  end

  // reset pin low-time filter
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pin_cnt_r <= 9'h000;
      pin_low_r <= 1'b0;
    end else if (i_clk_en) begin
      if (i_reset_pin_n) begin
        pin_cnt_r <= 9'h000;
        pin_low_r <= 1'b0;
      end else if (pin_cnt_r == 9'(rsw_pkg::PIN_MIN_CYCLES - 1)) begin
        pin_low_r <= 1'b1;
      end else begin
        pin_cnt_r <= pin_cnt_r + 9'h001;
      end
    end
  end

  // supply drop qualification and power-up source
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      drop_cnt_r <= 4'h0;
      drop_r     <= 1'b0;
      pwr_r      <= 1'b0;
    end else if (i_clk_en) begin
      pwr_r <= i_power_low;
      if (!(det_en_r && i_supply_below_level)) begin
        drop_cnt_r <= 4'h0;
        drop_r     <= 1'b0;
      end else if (drop_cnt_r == 4'(rsw_pkg::DROP_MIN_CYCLES - 1)) begin
        drop_r <= 1'b1;
      end else begin
        drop_cnt_r <= drop_cnt_r + 4'h1;
      end
    end
  end

  // all active sources merged
  assign any_src = pin_low_r | drop_r | pwr_r | wd_pulse_r;

  // start-up stretch after the last source goes quiet
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dly_cnt_r  <= STARTUP_CYCLES;
      core_rst_r <= 1'b1;
    end else if (i_clk_en) begin
      if (any_src) begin
        dly_cnt_r <= STARTUP_CYCLES;
      end else if (dly_cnt_r != 16'h0000) begin
        dly_cnt_r <= dly_cnt_r - 16'h0001;
      end
      core_rst_r <= any_src | (dly_cnt_r != 16'h0000);
    end
  end

  // reset cause flags, an event wins over a software clear
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cause_r <= rsw_pkg::CAUSE_RESET;
    end else if (i_clk_en) begin
      if (pwr_r) begin
        cause_r[rsw_pkg::CAUSE_PWR_BIT] <= 1'b1;
      end else if (wr_cause && !wdat[rsw_pkg::CAUSE_PWR_BIT]) begin
        cause_r[rsw_pkg::CAUSE_PWR_BIT] <= 1'b0;
      end
      if (pwr_r) begin
        cause_r[rsw_pkg::CAUSE_WDOG_BIT] <= 1'b0;
      end else if (wd_pulse_r) begin
        cause_r[rsw_pkg::CAUSE_WDOG_BIT] <= 1'b1;
      end else if (wr_cause && !wdat[rsw_pkg::CAUSE_WDOG_BIT]) begin
        cause_r[rsw_pkg::CAUSE_WDOG_BIT] <= 1'b0;
      end
      if (pwr_r) begin
        cause_r[rsw_pkg::CAUSE_DROP_BIT] <= 1'b0;
      end else if (drop_r) begin
        cause_r[rsw_pkg::CAUSE_DROP_BIT] <= 1'b1;
      end else if (wr_cause && !wdat[rsw_pkg::CAUSE_DROP_BIT]) begin
        cause_r[rsw_pkg::CAUSE_DROP_BIT] <= 1'b0;
      end
      if (pwr_r) begin
        cause_r[rsw_pkg::CAUSE_PIN_BIT] <= 1'b0;
      end else if (pin_low_r) begin
        cause_r[rsw_pkg::CAUSE_PIN_BIT] <= 1'b1;
      end else if (wr_cause && !wdat[rsw_pkg::CAUSE_PIN_BIT]) begin
        cause_r[rsw_pkg::CAUSE_PIN_BIT] <= 1'b0;
      end
    end
  end

  // effective enables after fuse override
  assign wde_eff  = wde_r | i_fuse.wdog_always_on;
  assign wdog_irq_enable_eff = wdog_irq_enable_r & ~i_fuse.wdog_always_on;
  assign wd_mode  = rsw_pkg::rsw_wdmode_e'({wde_eff, wdog_irq_enable_eff});

  // change enable window
  always_ff @(posedge i_mclk) begin
    if (i_reset || (core_rst_r && i_clk_en)) begin
      wdog_change_enable_r   <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (i_clk_en) begin
      if (ce_open) begin
        wdog_change_enable_r   <= 1'b1;
        ce_cnt_r <= rsw_pkg::CE_WINDOW_CYCLES;
      end else if (wr_ctl && wdog_change_enable_r) begin
        wdog_change_enable_r   <= 1'b0;
        ce_cnt_r <= 3'h0;
      end else if (ce_cnt_r == 3'h1) begin
        wdog_change_enable_r   <= 1'b0;
        ce_cnt_r <= 3'h0;
      end else if (ce_cnt_r != 3'h0) begin
        ce_cnt_r <= ce_cnt_r - 3'h1;
      end
    end
  end

  // reset enable and prescale, prescale changes and enable clears guarded by the window
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wde_r <= 1'b0;
      wdp_r <= rsw_pkg::WDP_RESET;
    end else if (i_clk_en) begin
      if (cause_r[rsw_pkg::CAUSE_WDOG_BIT]) begin
        wde_r <= 1'b1;
      end else if (core_rst_r) begin
        wde_r <= 1'b0;
      end else if (wr_ctl && wdog_change_enable_r && !wdat[rsw_pkg::WD_CE_BIT]) begin
        wde_r <= wdat[rsw_pkg::WD_RE_BIT];
      end else if (wr_ctl && wdat[rsw_pkg::WD_RE_BIT]) begin
        wde_r <= 1'b1;
      end
      if (core_rst_r) begin
        wdp_r <= rsw_pkg::WDP_RESET;
      end else if (wr_ctl && wdog_change_enable_r && !wdat[rsw_pkg::WD_CE_BIT]) begin
        wdp_r <= {wdat[rsw_pkg::WD_PS3_BIT], wdat[2:0]};
      end
    end
  end

  // time-out limit from the prescale select
  assign wdp_use  = (wdp_r > rsw_pkg::WD_PS_MAX) ? rsw_pkg::WD_PS_MAX : wdp_r;
  assign wd_limit = WDOG_BASE << wdp_use;

  // watchdog counter on oscillator ticks
  assign wd_expire = i_wdog_osc_tick & (wd_cnt_r == wd_limit - 21'h000001) &
                     (wd_mode != rsw_pkg::WD_STOPPED);
  always_ff @(posedge i_mclk) begin
    if (i_reset || (core_rst_r && i_clk_en)) begin
      wd_cnt_r <= 21'h000000;
    end else if (i_clk_en) begin
      if (i_wdog_restart || wd_mode == rsw_pkg::WD_STOPPED) begin
        wd_cnt_r <= 21'h000000;
      end else if (wd_expire) begin
        wd_cnt_r <= 21'h000000;
      end else if (i_wdog_osc_tick) begin
        wd_cnt_r <= wd_cnt_r + 21'h000001;
      end
    end
  end

  // time-out action by mode
  always_comb begin
    wd_irq_set = 1'b0;
    wd_rst_req = 1'b0;
    case (wd_mode)
      rsw_pkg::WD_STOPPED: begin
        wd_irq_set = 1'b0;
      end
      rsw_pkg::WD_IRQ: begin
        wd_irq_set = wd_expire;
      end
      rsw_pkg::WD_RESET: begin
        wd_rst_req = wd_expire;
      end
      rsw_pkg::WD_IRQ_RESET: begin
        wd_irq_set = wd_expire & ~wdog_irq_flag_r;
        wd_rst_req = wd_expire & wdog_irq_flag_r;
      end
      default: begin
        wd_rst_req = wd_expire;
      end
    endcase
  end

  // one-cycle watchdog reset pulse
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      wd_pulse_r <= 1'b0;
    end else if (i_clk_en) begin
      wd_pulse_r <= wd_rst_req & ~wd_pulse_r;
    end
  end

  // interrupt flag and enable
  always_ff @(posedge i_mclk) begin
    if (i_reset || (core_rst_r && i_clk_en)) begin
      wdog_irq_flag_r <= 1'b0;
      wdog_irq_enable_r <= 1'b0;
    end else if (i_clk_en) begin
      if (wd_irq_set) begin
        wdog_irq_flag_r <= 1'b1;
      end else if (i_wdog_vector_ack) begin
        wdog_irq_flag_r <= 1'b0;
      end else if (wr_ctl && wdat[rsw_pkg::WD_IRQF_BIT]) begin
        wdog_irq_flag_r <= 1'b0;
      end
      if (wr_ctl) begin
        wdog_irq_enable_r <= wdat[rsw_pkg::WD_IRQE_BIT];
      end else if (i_wdog_vector_ack && wd_mode == rsw_pkg::WD_IRQ_RESET) begin
        wdog_irq_enable_r <= 1'b0;
      end
    end
  end

  // interrupt and wake outputs
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else if (i_clk_en) begin
      irq_r  <= (wdog_irq_flag_r | wd_irq_set) & wdog_irq_enable_eff & ~core_rst_r;
      wake_r <= wd_irq_set;
    end
  end

  // APB slave: ready one cycle after setup, read data captured there
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      apb_r <= '0;
    end else if (i_clk_en) begin
      apb_r.pready  <= i_apb.psel & ~i_apb.penable;
      apb_r.pslverr <= i_apb.psel & ~i_apb.penable & (reg_sel(i_apb.paddr) == 2'h0);
      apb_r.prdata  <= 32'h00000000;
      if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
        case (reg_sel(i_apb.paddr))
          2'h1: apb_r.prdata <= {24'h000000, cause_r};
          2'h2: apb_r.prdata <= {24'h000000, wdog_irq_flag_r, wdog_irq_enable_eff, wdp_r[3], wdog_change_enable_r,
                                 wde_eff, wdp_r[2:0]};
          default: apb_r.prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // outputs straight from flops
  assign o_apb                     = apb_r;
  assign o_core_reset              = core_rst_r;
  assign o_wdog_irq                = irq_r;
  assign o_wdog_wake               = wake_r;
  assign o_supply_drop_detector_en = det_en_r;
  assign o_supply_drop_level       = level_r;

endmodule : rsw_reset_wdog

// ### hw/rsw_pkg.sv
// rsw_pkg: constants, types and carriers of the reset source and watchdog block
// assumes a 125 MHz system clock and an APB slave with 32-bit data
package rsw_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_WDCTL = 8'h04;

  // cause flag bit positions
  localparam int CAUSE_WDOG_BIT = 3;
  localparam int CAUSE_DROP_BIT = 2;
  localparam int CAUSE_PIN_BIT  = 1;
  localparam int CAUSE_PWR_BIT  = 0;

  // watchdog control bit positions, prescale bits 5 and 2..0
  localparam int WD_IRQF_BIT = 7;
  localparam int WD_IRQE_BIT = 6;
  localparam int WD_PS3_BIT  = 5;
  localparam int WD_CE_BIT   = 4;
  localparam int WD_RE_BIT   = 3;

  // supply drop level fuse codes
  localparam logic [2:0] LVL_OFF = 3'h7;
  localparam logic [2:0] LVL_1V8 = 3'h6;
  localparam logic [2:0] LVL_2V7 = 3'h5;
  localparam logic [2:0] LVL_4V3 = 3'h4;

  // prescale: largest defined select, base period in oscillator cycles
  localparam logic [3:0]  WD_PS_MAX  = 4'h9;
  localparam logic [20:0] WD_BASE    = 21'h000800;

  // timing
  localparam int CLK_PERIOD_NS  = 8;
  localparam int PIN_MIN_NS     = 2500;
  localparam int PIN_MIN_CYCLES = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DROP_MIN_NS    = 2;
  localparam int DROP_CYC_RAW   = (DROP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DROP_MIN_CYCLES = (DROP_CYC_RAW < 1) ? 1 : DROP_CYC_RAW;
  localparam logic [2:0]  CE_WINDOW_CYCLES = 3'h4;
  localparam logic [15:0] STARTUP_DEFAULT  = 16'h1000;

  // reset values
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [3:0] WDP_RESET   = 4'h0;

  typedef enum logic [1:0] {
    LEVEL_NONE, LEVEL_1V8, LEVEL_2V7, LEVEL_4V3
  } rsw_level_e;

  typedef enum logic [1:0] {
    WD_STOPPED, WD_IRQ, WD_RESET, WD_IRQ_RESET
  } rsw_wdmode_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rsw_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } rsw_apb_rsp_s;

  typedef struct packed {
    logic [2:0] drop_level;
    logic       wdog_always_on;
  } rsw_fuse_s;

endpackage : rsw_pkg

// ### sim/rsw_chk.sv
// rsw_chk: port-level assertions for the reset source and watchdog block
// assumes a single reset at the start; cycles with the clock enable low are not checked
`timescale 1ns/1ps
module rsw_chk #(
  parameter logic [15:0] STARTUP_CYCLES = rsw_pkg::STARTUP_DEFAULT
) (
  input wire logic                  i_mclk,
  input wire logic                  i_reset,
  input wire logic                  i_clk_en,
  input wire rsw_pkg::rsw_apb_req_s i_apb,
  input wire rsw_pkg::rsw_apb_rsp_s o_apb,
  input wire rsw_pkg::rsw_fuse_s    i_fuse,
  input wire logic                  i_power_low,
  input wire logic                  i_supply_below_level,
  input wire logic                  o_core_reset,
  input wire logic                  o_wdog_irq,
  input wire logic                  o_wdog_wake,
  input wire logic                  o_supply_drop_detector_en,
  input wire rsw_pkg::rsw_level_e   o_supply_drop_level
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset || !i_clk_en);
  logic [15:0] quiet_r;
  logic [2:0]  fuse_d_r;
  // quiet time since reset or power-low, and the fuse one cycle back
  always_ff @(posedge i_mclk) begin
    fuse_d_r <= i_fuse.drop_level;
    if (i_reset || i_power_low) quiet_r <= 16'h0000;
    else if (quiet_r != 16'hFFFF) quiet_r <= quiet_r + 16'h0001;
  end
  apb_ready_a: assert property (i_apb.psel && !i_apb.penable |=> o_apb.pready)
    else $error("pready missing after setup");
  apb_stand_a: assert property (o_apb.pready |=> !o_apb.pready) else $error("pready stuck");
  bad_addr_a: assert property (o_apb.pready && i_apb.paddr != rsw_pkg::ADDR_CAUSE &&
    i_apb.paddr != rsw_pkg::ADDR_WDCTL |-> o_apb.pslverr && o_apb.prdata == 32'h0)
    else $error("unmapped access not refused");
  startup_hold_a: assert property ($fell(o_core_reset) |-> quiet_r > STARTUP_CYCLES)
    else $error("core reset released early");
  power_rst_a: assert property (i_power_low |-> ##2 o_core_reset)
    else $error("power low without core reset");
  drop_rst_a: assert property (i_supply_below_level && o_supply_drop_detector_en
    |-> ##2 o_core_reset) else $error("supply drop without core reset");
  drop_en_a: assert property (!$past(i_reset) |->
    o_supply_drop_detector_en == (fuse_d_r inside {3'h4, 3'h5, 3'h6}))
    else $error("detector enable wrong");
  drop_lvl_a: assert property (!$past(i_reset) |-> o_supply_drop_level ==
    (fuse_d_r == rsw_pkg::LVL_1V8 ? rsw_pkg::LEVEL_1V8 : fuse_d_r == rsw_pkg::LVL_2V7 ?
     rsw_pkg::LEVEL_2V7 : fuse_d_r == rsw_pkg::LVL_4V3 ? rsw_pkg::LEVEL_4V3 : rsw_pkg::LEVEL_NONE))
    else $error("detector level wrong");
  wake_irq_a: assert property (o_wdog_wake |-> o_wdog_irq) else $error("wake without irq");
  wake_pulse_a: assert property (o_wdog_wake |=> !o_wdog_wake) else $error("wake too long");
  lock_on_a: assert property (o_apb.pready && !i_apb.pwrite && i_fuse.wdog_always_on
    && i_apb.paddr == rsw_pkg::ADDR_WDCTL && $past(i_fuse.wdog_always_on, 3)
    |-> !o_apb.prdata[6] && o_apb.prdata[3]) else $error("always-on mode not forced");
endmodule : rsw_chk

bind rsw_reset_wdog rsw_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
  .i_mclk(i_mclk), .i_reset(i_reset), .i_clk_en(i_clk_en), .i_apb(i_apb), .o_apb(o_apb),
  .i_fuse(i_fuse),
  .i_power_low(i_power_low), .i_supply_below_level(i_supply_below_level),
  .o_core_reset(o_core_reset), .o_wdog_irq(o_wdog_irq), .o_wdog_wake(o_wdog_wake),
  .o_supply_drop_detector_en(o_supply_drop_detector_en),
  .o_supply_drop_level(o_supply_drop_level));

// ### sim/rsw_core_model.sv
// rsw_core_model: watchdog oscillator and the core's interrupt vector entry
// assumes the system clock; the oscillator is scaled down for simulation
`timescale 1ns/1ps
module rsw_core_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_irq,
  input  wire logic i_ack_en,
  output logic      o_osc_tick,
  output logic      o_vector_ack
);
  logic [7:0] div_r;
  logic       acked_r;
  // free running oscillator, one tick every TICK_DIV cycles
  always_ff @(posedge i_mclk) begin
    if (i_reset || div_r == 8'(TICK_DIV - 1)) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end
  assign o_osc_tick = (div_r == 8'h00);
  // vector entry once per raised interrupt, only while enabled
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_vector_ack <= 1'b0;
      acked_r      <= 1'b0;
    end else begin
      o_vector_ack <= i_irq && i_ack_en && !acked_r && !o_vector_ack;
      acked_r      <= i_irq && (acked_r || o_vector_ack);
    end
  end
endmodule : rsw_core_model

// ### sim/rsw_reset_wdog_test.sv
// rsw_reset_wdog_test: self-checking bench for the reset source and watchdog block
// assumes shortened start-up and watchdog counts; clock enable dropped once to check the freeze
`timescale 1ns/1ps
module rsw_reset_wdog_test;
  logic                  i_mclk = 1'b0;
  logic                  i_reset = 1'b1;
  rsw_pkg::rsw_apb_req_s req = '0;
  rsw_pkg::rsw_apb_rsp_s rsp;
  rsw_pkg::rsw_fuse_s    fuse = '0;
  rsw_pkg::rsw_level_e   lvl;
  logic pin_n = 1'b1, pwr_low = 1'b0, below = 1'b0, restart = 1'b1, ack_en = 1'b0, clk_en = 1'b1;
  logic tick, ack, core_rst, irq, wake, det_en;
  logic [7:0]  exp_q[$];
  logic [31:0] lfsr = 32'hB408B61B;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  localparam logic [7:0] CA = rsw_pkg::ADDR_CAUSE;
  localparam logic [7:0] WD = rsw_pkg::ADDR_WDCTL;

  rsw_reset_wdog #(.STARTUP_CYCLES(16'h000A), .WDOG_BASE(21'h000004)) dut_u (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_clk_en(clk_en), .i_apb(req), .o_apb(rsp),
    .i_fuse(fuse), .i_reset_pin_n(pin_n), .i_power_low(pwr_low),
    .i_supply_below_level(below), .i_wdog_osc_tick(tick), .i_wdog_restart(restart),
    .i_wdog_vector_ack(ack), .o_core_reset(core_rst), .o_wdog_irq(irq), .o_wdog_wake(wake),
    .o_supply_drop_detector_en(det_en), .o_supply_drop_level(lvl));
  rsw_core_model #(.TICK_DIV(4)) core_u (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_irq(irq), .i_ack_en(ack_en),
    .o_osc_tick(tick), .o_vector_ack(ack));

  // clock and hang guard
  always #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares = miscompares + 1;
      report_and_stop();
    end
  end
  // read results against the oldest note
  always @(posedge i_mclk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
      cmp8(rsp.prdata[7:0], exp_q.pop_front());
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : cmp8
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : step
  task automatic wait_on(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? core_rst : irq) !== val && n < lim) begin
      @(posedge i_mclk);
      n++;
    end
    if (n == lim) cmp8({7'h0, ~val}, {7'h0, val});
  endtask : wait_on
  // one transfer; keep leaves the bus up for a back-to-back setup
  task automatic apb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic keep);
    req <= '{1'b1, 1'b0, we, a, {24'h0, d}};
    @(posedge i_mclk);
    req.penable <= 1'b1;
    do @(posedge i_mclk); while (rsp.pready !== 1'b1);
    if (!keep) begin
      req <= '{1'b0, 1'b0, we, a, {24'h0, d}};
      @(posedge i_mclk);
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 8'h00, 1'b0);
  endtask : rd
  task automatic report_and_stop();
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    step(20);
    i_reset <= 1'b0;
    pwr_low <= 1'b1;
    step(4);
    pwr_low <= 1'b0;
    wait_on(0, 1'b0, 100);
    rd(CA, 8'h01);
    pin_n <= 1'b0;
    step(300);
    pin_n <= 1'b1;
    step(4);
    rd(CA, 8'h01);
    pin_n <= 1'b0;
    wait_on(0, 1'b1, 400);
    pin_n <= 1'b1;
    wait_on(0, 1'b0, 100);
    rd(CA, 8'h03);
    lfsr = lfsr_next(lfsr);
    wr(CA, lfsr[7:0]);
    rd(CA, 8'h03 & lfsr[7:0]);
    wr(CA, 8'h00);
    for (int i = 0; i < 8; i++) begin
      fuse.drop_level <= 3'(i);
      step(3);
    end
    below <= 1'b1;
    step(3);
    below <= 1'b0;
    step(3);
    rd(CA, 8'h00);
    fuse.drop_level <= rsw_pkg::LVL_2V7;
    step(3);
    below <= 1'b1;
    step(1);
    below <= 1'b0;
    wait_on(0, 1'b1, 10);
    wait_on(0, 1'b0, 100);
    rd(CA, 8'h04);
    wr(CA, 8'h00);
    rd(8'h08, 8'h00);
    restart <= 1'b0;
    wr(WD, 8'h08);
    wait_on(0, 1'b1, 100);
    restart <= 1'b1;
    wait_on(0, 1'b0, 100);
    rd(CA, 8'h08);
    rd(WD, 8'h08);
    wr(CA, 8'h00);
    wr(WD, 8'h18);
    step(6);
    wr(WD, 8'h00);
    rd(WD, 8'h08);
    apb(1'b1, WD, 8'h18, 1'b1);
    wr(WD, 8'h05);
    rd(WD, 8'h05);
    wr(WD, 8'h45);
    restart <= 1'b0;
    step(480);
    cmp8({7'h0, irq}, 8'h00);
    wait_on(1, 1'b1, 100);
    restart <= 1'b1;
    wr(WD, 8'hC5);
    rd(WD, 8'h45);
    ack_en <= 1'b1;
    wr(WD, 8'h4D);
    restart <= 1'b0;
    wait_on(1, 1'b1, 1000);
    step(4);
    restart <= 1'b1;
    rd(WD, 8'h0D);
    restart <= 1'b0;
    wait_on(0, 1'b1, 1000);
    restart <= 1'b1;
    wait_on(0, 1'b0, 100);
    rd(CA, 8'h08);
    fuse.wdog_always_on <= 1'b1;
    wr(WD, 8'h40);
    rd(WD, 8'h08);
    // a power-low burst while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    pwr_low <= 1'b1;
    step(3);
    pwr_low <= 1'b0;
    step(1);
    clk_en <= 1'b1;
    step(2);
    cmp8({7'h0, core_rst}, 8'h00);
    rd(CA, 8'h08);
    report_and_stop();
  end
endmodule : rsw_reset_wdog_test
